// ==== rtl/light_sensor_pkg.sv ====
// shared constants and types for the light sensor register bank
package light_sensor_pkg;

   // register addresses, low nibble of the command byte
   localparam logic [3:0] ADDR_POWER = 4'h0;
   localparam logic [3:0] ADDR_TIMING = 4'h1;
   localparam logic [3:0] ADDR_LOW_LSB = 4'h2;
   localparam logic [3:0] ADDR_HIGH_MSB = 4'h5;
   localparam logic [3:0] ADDR_ALERT = 4'h6;
   localparam logic [3:0] ADDR_FACTORY = 4'h8;
   localparam logic [3:0] ADDR_PART_REV = 4'hA;
   localparam logic [3:0] ADDR_BLOCK_ALL = 4'hB;
   localparam logic [3:0] ADDR_CH0_LSB = 4'hC;
   localparam logic [3:0] ADDR_CH0_MSB = 4'hD;
   localparam logic [3:0] ADDR_CH1_LSB = 4'hE;
   localparam logic [3:0] ADDR_CH1_MSB = 4'hF;

   // command byte fields
   localparam int CMD_SELECT_BIT = 7;
   localparam int CMD_CLEAR_BIT = 6;
   localparam int CMD_WORD_BIT = 5;
   localparam int CMD_BLOCK_BIT = 4;

   // timing register fields
   localparam int TIM_GAIN_BIT = 4;
   localparam int TIM_MANUAL_BIT = 3;
   localparam logic [1:0] INTEGRATION_SELECT_FAST = 2'b00;
   localparam logic [1:0] INTEGRATION_SELECT_MEDIUM = 2'b01;
   localparam logic [1:0] INTEGRATION_SELECT_MANUAL = 2'b11;

   // reset values and writable masks
   localparam logic [7:0] TARGET_RESET = 8'h00;
   localparam logic [1:0] POWER_RESET = 2'b00;
   localparam logic [1:0] POWER_UP = 2'b11;
   localparam logic [7:0] TIMING_RESET = 8'h02;
   localparam logic [7:0] TIMING_MASK = 8'h1B;
   localparam logic [7:0] THRESH_RESET = 8'h00;
   localparam logic [7:0] ALERT_RESET = 8'h00;
   localparam logic [7:0] ALERT_MASK = 8'h3F;

   // smbus block read of all four result bytes
   localparam logic [7:0] BLOCK_READ_CODE = 8'h9B;
   localparam logic [7:0] BLOCK_READ_COUNT = 8'h04;

   // arbitrary identification value
   localparam logic [7:0] PART_REV_VALUE = 8'h5A;

   // slave addresses chosen by the address strap
   localparam logic [6:0] SLAVE_ADDR_GND = 7'h29;
   localparam logic [6:0] SLAVE_ADDR_FLOAT = 7'h39;
   localparam logic [6:0] SLAVE_ADDR_VDD = 7'h49;
   localparam logic [1:0] STRAP_GND = 2'b00;
   localparam logic [1:0] STRAP_FLOAT = 2'b01;

   // integration times and their cycle counts at the core clock
   localparam real CLK_PERIOD_NS = 5.0;
   localparam real INTEGRATION_SELECT_FAST_MS = 13.7;
   localparam real INTEGRATION_SELECT_MEDIUM_MS = 101.0;
   localparam real INTEGRATION_SELECT_SLOW_MS = 402.0;
   localparam int unsigned INTEGRATION_SELECT_FAST_CYCLES =
      $rtoi(INTEGRATION_SELECT_FAST_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned INTEGRATION_SELECT_MEDIUM_CYCLES =
      $rtoi(INTEGRATION_SELECT_MEDIUM_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned INTEGRATION_SELECT_SLOW_CYCLES =
      $rtoi(INTEGRATION_SELECT_SLOW_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int CNT_W = 27;

   // serial link states
   typedef enum logic [2:0] {
      LINK_IDLE,
      LINK_ADDR,
      LINK_ADDR_ACK,
      LINK_WRITE,
      LINK_WRITE_ACK,
      LINK_READ,
      LINK_READ_ACK
   } link_state_type;

endpackage

// ==== rtl/integration_sequencer.sv ====
// integration timing and single-register result capture for both channels
`timescale 1ns/1ps
module integration_sequencer #(
   parameter int unsigned FAST_CYCLES = light_sensor_pkg::INTEGRATION_SELECT_FAST_CYCLES,
   parameter int unsigned MEDIUM_CYCLES =
      light_sensor_pkg::INTEGRATION_SELECT_MEDIUM_CYCLES,
   parameter int unsigned SLOW_CYCLES = light_sensor_pkg::INTEGRATION_SELECT_SLOW_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic power_on,
   input wire logic [1:0] integration_select_select,
   input wire logic manual_start,
   input wire logic [15:0] ch0_count,
   input wire logic [15:0] ch1_count,
   output logic integrating_q,
   output logic conv_done_q,
   output logic [15:0] ch0_result_q,
   output logic [15:0] ch1_result_q
);
   localparam int W = light_sensor_pkg::CNT_W;

   logic [W-1:0] count_q, count_d; // cycles into the current period
   logic integrating_d;
   logic conv_done_d;
   logic [15:0] ch0_result_d, ch1_result_d;

   // last count of a period for the selected integration time
   function automatic logic [W-1:0] last_count(input logic [1:0] sel);
      if (sel == light_sensor_pkg::INTEGRATION_SELECT_FAST) begin
         last_count = W'(FAST_CYCLES - 1);
      end else if (sel == light_sensor_pkg::INTEGRATION_SELECT_MEDIUM) begin
         last_count = W'(MEDIUM_CYCLES - 1);
      end else begin
         last_count = W'(SLOW_CYCLES - 1);
      end
   endfunction

   // next state of the integration sequence
   always_comb begin
      count_d = count_q;
      integrating_d = integrating_q;
      conv_done_d = 1'b0;
      ch0_result_d = ch0_result_q;
      ch1_result_d = ch1_result_q;
      if (!power_on) begin
         // powered down: integration held, results kept readable
         count_d = '0;
         integrating_d = 1'b0;
      end else if (integration_select_select == light_sensor_pkg::INTEGRATION_SELECT_MANUAL) begin
         // host starts and stops the period by hand
         count_d = '0;
         integrating_d = manual_start;
         if (integrating_q && !manual_start) begin
            conv_done_d = 1'b1;
            ch0_result_d = ch0_count;
            ch1_result_d = ch1_count;
         end
      end else begin
         // one shared period for both channels, restarted on its own
         integrating_d = 1'b1;
         if (count_q >= last_count(integration_select_select)) begin
            count_d = '0;
            conv_done_d = 1'b1;
            ch0_result_d = ch0_count;
            ch1_result_d = ch1_count;
         end else begin
            count_d = count_q + W'(1);
         end
      end
   end

   // register the sequence, frozen while the clock enable is low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= '0;
         integrating_q <= 1'b0;
         conv_done_q <= 1'b0;
         ch0_result_q <= 16'h0000;
         ch1_result_q <= 16'h0000;
      end else if (clk_en) begin
         count_q <= count_d;
         integrating_q <= integrating_d;
         conv_done_q <= conv_done_d;
         ch0_result_q <= ch0_result_d;
         ch1_result_q <= ch1_result_d;
      end
   end

endmodule // integration_sequencer

// ==== rtl/light_sensor_register_bank.sv ====
// two-wire serial slave, command decode and register bank of the sensor
// How it works
// - send byte loads command; address kept afterwards
// - command register clears to zero at reset
// - clear bit pulses interrupt clear, never stored
// - word bit marks two-byte transfer
// - block bit marks block transfer
// - low nibble of command is register address
// - decode power, timing, thresholds, alert, id, results
// - results low byte lower address, high next
// - block transfers run until stop; write count byte dropped
// - code 9Bh reads count four then results
// - power field 03h up, 00h down
// - power register reads back written value
// - timing register resets to 02h
// - timing bit 4 selects sixteen-times gain
// - timing bits 1:0 pick integration period
// - manual bit starts/stops only in manual select
// - one gain and period for both channels
// - first byte with top bit set is command
// - receive byte returns selected register
// - finished conversion latches both results; timed modes restart
`timescale 1ns/1ps
module light_sensor_register_bank #(
   parameter int unsigned FAST_CYCLES = light_sensor_pkg::INTEGRATION_SELECT_FAST_CYCLES,
   parameter int unsigned MEDIUM_CYCLES =
      light_sensor_pkg::INTEGRATION_SELECT_MEDIUM_CYCLES,
   parameter int unsigned SLOW_CYCLES = light_sensor_pkg::INTEGRATION_SELECT_SLOW_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [1:0] addr_sel,
   input wire logic [15:0] ch0_count,
   input wire logic [15:0] ch1_count,
   output logic power_on,
   output logic gain_high,
   output logic integrating,
   output logic result_ready,
   output logic irq_clear,
   output logic [15:0] low_threshold,
   output logic [15:0] high_threshold,
   output logic [7:0] alert_config
);

   // pin synchronisers; the meta stage feeds only the sync stage
   logic scl_meta_q, scl_sync_q, scl_prev_q;
   logic sda_meta_q, sda_sync_q, sda_prev_q;
   logic [1:0] strap_meta_q, strap_sync_q;
   logic [6:0] slave_addr_q; // strap address, refreshed every enabled cycle

   // link engine state
   light_sensor_pkg::link_state_type state_q, state_d;
   logic [3:0] bit_cnt_q, bit_cnt_d; // bits moved in this byte
   logic [7:0] shift_q, shift_d; // serial shift register
   logic sda_oe_q, sda_oe_d; // pulls the data line low
   logic is_read_q, is_read_d; // direction of the transaction
   logic first_q, first_d; // next byte is the first after address
   logic skip_count_q, skip_count_d; // drop smbus byte count
   logic [3:0] cur_addr_q, cur_addr_d; // working register pointer

   // register bank
   logic [7:0] target_q, target_d; // stored command byte
   logic [1:0] power_q, power_d;
   logic [7:0] timing_q, timing_d;
   logic [7:0] thresh_q [0:3];
   logic [7:0] thresh_d [0:3];
   logic [7:0] alert_q, alert_d;
   logic irq_clear_q, irq_clear_d; // one-cycle clear pulse

   // sequencer outputs
   logic [15:0] ch0_result, ch1_result;

   // edge and bus condition detection on synchronised pins
   logic scl_rise, scl_fall, start_seen, stop_seen;
   assign scl_rise = scl_sync_q && !scl_prev_q;
   assign scl_fall = !scl_sync_q && scl_prev_q;
   assign start_seen = scl_sync_q && scl_prev_q && sda_prev_q && !sda_sync_q;
   assign stop_seen = scl_sync_q && scl_prev_q && !sda_prev_q && sda_sync_q;

   // strap level to slave address
   function automatic logic [6:0] strap_addr(input logic [1:0] s);
      if (s == light_sensor_pkg::STRAP_GND) begin
         strap_addr = light_sensor_pkg::SLAVE_ADDR_GND;
      end else if (s == light_sensor_pkg::STRAP_FLOAT) begin
         strap_addr = light_sensor_pkg::SLAVE_ADDR_FLOAT;
      end else begin
         strap_addr = light_sensor_pkg::SLAVE_ADDR_VDD;
      end
   endfunction

   // read decode, used for every read byte except the 9Bh count byte
   function automatic logic [7:0] read_reg(input logic [3:0] a);
      if (a == light_sensor_pkg::ADDR_POWER) begin
         read_reg = {6'b00_0000, power_q};
      end else if (a == light_sensor_pkg::ADDR_TIMING) begin
         read_reg = timing_q;
      end else if (a >= light_sensor_pkg::ADDR_LOW_LSB &&
                   a <= light_sensor_pkg::ADDR_HIGH_MSB) begin
         read_reg = thresh_q[2'(a - light_sensor_pkg::ADDR_LOW_LSB)];
      end else if (a == light_sensor_pkg::ADDR_ALERT) begin
         read_reg = alert_q;
      end else if (a == light_sensor_pkg::ADDR_PART_REV) begin
         read_reg = light_sensor_pkg::PART_REV_VALUE;
      end else if (a == light_sensor_pkg::ADDR_CH0_LSB) begin
         read_reg = ch0_result[7:0];
      end else if (a == light_sensor_pkg::ADDR_CH0_MSB) begin
         read_reg = ch0_result[15:8];
      end else if (a == light_sensor_pkg::ADDR_CH1_LSB) begin
         read_reg = ch1_result[7:0];
      end else if (a == light_sensor_pkg::ADDR_CH1_MSB) begin
         read_reg = ch1_result[15:8];
      end else begin
         read_reg = 8'h00;
      end
   endfunction

   // multi-byte transfers step the pointer, plain bytes keep it
   function automatic logic [3:0] step_addr(input logic [3:0] a,
                                            input logic [7:0] cmd);
      if (cmd[light_sensor_pkg::CMD_WORD_BIT] ||
          cmd[light_sensor_pkg::CMD_BLOCK_BIT]) begin
         step_addr = a + 4'h1;
      end else begin
         step_addr = a;
      end
   endfunction

   // serial link and register write next-state logic
   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      sda_oe_d = sda_oe_q;
      is_read_d = is_read_q;
      first_d = first_q;
      skip_count_d = skip_count_q;
      cur_addr_d = cur_addr_q;
      target_d = target_q;
      power_d = power_q;
      timing_d = timing_q;
      thresh_d = thresh_q;
      alert_d = alert_q;
      irq_clear_d = 1'b0;
      if (start_seen) begin
         // start or repeated start: hunt for our address
         state_d = light_sensor_pkg::LINK_ADDR;
         bit_cnt_d = 4'h0;
         sda_oe_d = 1'b0;
      end else if (stop_seen) begin
         // stop ends any transfer, block ones included
         state_d = light_sensor_pkg::LINK_IDLE;
         sda_oe_d = 1'b0;
      end else begin
         case (state_q)
            light_sensor_pkg::LINK_ADDR: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_sync_q};
                  bit_cnt_d = bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == 4'h8) begin
                  if (shift_q[7:1] == slave_addr_q) begin
                     // acknowledge and start at the stored address
                     sda_oe_d = 1'b1;
                     is_read_d = shift_q[0];
                     first_d = 1'b1;
                     skip_count_d = 1'b0;
                     cur_addr_d = target_q[3:0];
                     state_d = light_sensor_pkg::LINK_ADDR_ACK;
                  end else begin
                     state_d = light_sensor_pkg::LINK_IDLE;
                  end
               end
            end
            light_sensor_pkg::LINK_WRITE: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_sync_q};
                  bit_cnt_d = bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == 4'h8) begin
                  sda_oe_d = 1'b1;
                  first_d = 1'b0;
                  state_d = light_sensor_pkg::LINK_WRITE_ACK;
                  if (first_q && shift_q[light_sensor_pkg::CMD_SELECT_BIT])
                  begin
                     // command byte: clear bit acts but is not kept
                     target_d = shift_q;
                     target_d[light_sensor_pkg::CMD_CLEAR_BIT] = 1'b0;
                     irq_clear_d = shift_q[light_sensor_pkg::CMD_CLEAR_BIT];
                     cur_addr_d = shift_q[3:0];
                     skip_count_d =
                        shift_q[light_sensor_pkg::CMD_BLOCK_BIT];
                  end else if (skip_count_q) begin
                     // byte count after a block command is ignored
                     skip_count_d = 1'b0;
                  end else begin
                     cur_addr_d = step_addr(cur_addr_q, target_q);
                     if (cur_addr_q == light_sensor_pkg::ADDR_POWER) begin
                        power_d = shift_q[1:0];
                     end else if (cur_addr_q ==
                                  light_sensor_pkg::ADDR_TIMING) begin
                        timing_d = shift_q &
                                   light_sensor_pkg::TIMING_MASK;
                     end else if (cur_addr_q >=
                                  light_sensor_pkg::ADDR_LOW_LSB &&
                                  cur_addr_q <=
                                  light_sensor_pkg::ADDR_HIGH_MSB) begin
                        thresh_d[2'(cur_addr_q -
                                 light_sensor_pkg::ADDR_LOW_LSB)] = shift_q;
                     end else if (cur_addr_q ==
                                  light_sensor_pkg::ADDR_ALERT) begin
                        alert_d = shift_q & light_sensor_pkg::ALERT_MASK;
                     end
                     // other addresses are read-only or reserved
                  end
               end
            end
            light_sensor_pkg::LINK_WRITE_ACK: begin
               if (scl_fall) begin
                  sda_oe_d = 1'b0;
                  bit_cnt_d = 4'h0;
                  state_d = light_sensor_pkg::LINK_WRITE;
               end
            end
            light_sensor_pkg::LINK_ADDR_ACK,
            light_sensor_pkg::LINK_READ_ACK: begin
               if (state_q == light_sensor_pkg::LINK_READ_ACK && scl_rise &&
                   sda_sync_q) begin
                  // master nack: stop sending until the next start
                  state_d = light_sensor_pkg::LINK_IDLE;
               end else if (scl_fall && !is_read_q) begin
                  sda_oe_d = 1'b0;
                  bit_cnt_d = 4'h0;
                  state_d = light_sensor_pkg::LINK_WRITE;
               end else if (scl_fall) begin
                  // load the next byte to send
                  bit_cnt_d = 4'h0;
                  first_d = 1'b0;
                  state_d = light_sensor_pkg::LINK_READ;
                  if (first_q && target_q ==
                      light_sensor_pkg::BLOCK_READ_CODE) begin
                     shift_d = light_sensor_pkg::BLOCK_READ_COUNT;
                     cur_addr_d = light_sensor_pkg::ADDR_CH0_LSB;
                  end else begin
                     shift_d = read_reg(cur_addr_q);
                     cur_addr_d = step_addr(cur_addr_q, target_q);
                  end
                  // msb goes out now; the line is pulled low for a zero
                  sda_oe_d = !shift_d[7];
               end
            end
            light_sensor_pkg::LINK_READ: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 4'h7) begin
                     // last bit done, release for the master's ack
                     sda_oe_d = 1'b0;
                     state_d = light_sensor_pkg::LINK_READ_ACK;
                  end else begin
                     bit_cnt_d = bit_cnt_q + 4'h1;
                     shift_d = {shift_q[6:0], 1'b0};
                     sda_oe_d = !shift_q[6];
                  end
               end
            end
            default: begin
               sda_oe_d = 1'b0;
            end
         endcase
      end
   end

   // pin synchronisers and the strap capture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_meta_q <= 1'b1;
         scl_sync_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_meta_q <= 1'b1;
         sda_sync_q <= 1'b1;
         sda_prev_q <= 1'b1;
         strap_meta_q <= 2'b00;
         strap_sync_q <= 2'b00;
         slave_addr_q <= light_sensor_pkg::SLAVE_ADDR_GND;
      end else if (clk_en) begin
         scl_meta_q <= scl_in;
         scl_sync_q <= scl_meta_q;
         scl_prev_q <= scl_sync_q;
         sda_meta_q <= sda_in;
         sda_sync_q <= sda_meta_q;
         sda_prev_q <= sda_sync_q;
         strap_meta_q <= addr_sel;
         strap_sync_q <= strap_meta_q;
         slave_addr_q <= strap_addr(strap_sync_q);
      end
   end

   // link and register state; reset values are the power-on ones
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= light_sensor_pkg::LINK_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         sda_oe_q <= 1'b0;
         is_read_q <= 1'b0;
         first_q <= 1'b0;
         skip_count_q <= 1'b0;
         cur_addr_q <= 4'h0;
         target_q <= light_sensor_pkg::TARGET_RESET;
         power_q <= light_sensor_pkg::POWER_RESET;
         timing_q <= light_sensor_pkg::TIMING_RESET;
         for (int i = 0; i < 4; i++) begin
            thresh_q[i] <= light_sensor_pkg::THRESH_RESET;
         end
         alert_q <= light_sensor_pkg::ALERT_RESET;
         irq_clear_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         sda_oe_q <= sda_oe_d;
         is_read_q <= is_read_d;
         first_q <= first_d;
         skip_count_q <= skip_count_d;
         cur_addr_q <= cur_addr_d;
         target_q <= target_d;
         power_q <= power_d;
         timing_q <= timing_d;
         thresh_q <= thresh_d;
         alert_q <= alert_d;
         irq_clear_q <= irq_clear_d;
      end
   end

   // output flops for the converter power and gain controls
   logic power_on_q, gain_high_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_on_q <= 1'b0;
         gain_high_q <= 1'b0;
      end else if (clk_en) begin
         power_on_q <= power_d == light_sensor_pkg::POWER_UP;
         gain_high_q <= timing_d[light_sensor_pkg::TIM_GAIN_BIT];
      end
   end

   // converter period control shared by both channels
   integration_sequencer #(
      .FAST_CYCLES(FAST_CYCLES),
      .MEDIUM_CYCLES(MEDIUM_CYCLES),
      .SLOW_CYCLES(SLOW_CYCLES)
   ) sequencer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .power_on(power_on_q),
      .integration_select_select(timing_q[1:0]),
      .manual_start(timing_q[light_sensor_pkg::TIM_MANUAL_BIT]),
      .ch0_count(ch0_count),
      .ch1_count(ch1_count),
      .integrating_q(integrating),
      .conv_done_q(result_ready),
      .ch0_result_q(ch0_result),
      .ch1_result_q(ch1_result)
   );

   // line is only ever pulled low, so the data level is always zero
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_q;
   assign power_on = power_on_q;
   assign gain_high = gain_high_q;
   assign irq_clear = irq_clear_q;
   assign low_threshold = {thresh_q[1], thresh_q[0]};
   assign high_threshold = {thresh_q[3], thresh_q[2]};
   assign alert_config = alert_q;

endmodule // light_sensor_register_bank

// ==== verification/lsrb_sva.sv ====
// port checker for the light sensor register bank
`timescale 1ns/1ps
module lsrb_chk (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic power_on,
   input wire logic gain_high,
   input wire logic integrating,
   input wire logic result_ready,
   input wire logic irq_clear,
   input wire logic [15:0] low_threshold,
   input wire logic [15:0] high_threshold
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // two cycles down: lets integrating settle one cycle late
   sequence down2; !power_on [*2]; endsequence
   chk_reset_vals: assert property (
      $rose(rst_b) |-> !power_on && !gain_high)
      else $error("outputs off their reset values");
   chk_clear_pulse: assert property (irq_clear |=> !irq_clear)
      else $error("interrupt clear stayed set");
   chk_ready_gap: assert property (
      result_ready |=> !result_ready [*8])
      else $error("results latched too often");
   chk_down_idle: assert property (down2 |-> !integrating)
      else $error("integrating while powered down");
   chk_oe_in_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   chk_gain_write: assert property ($changed(gain_high) |-> !scl_in)
      else $error("gain moved outside a write");
   chk_low_thr: assert property ($changed(low_threshold) |-> !scl_in)
      else $error("low threshold moved outside a write");
   chk_open_drain: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   // result flop follows the power flop one cycle late
   chk_ready_power: assert property (result_ready |-> $past(power_on))
      else $error("result while powered down");
   cover property (irq_clear);
   cover property (result_ready);
   cover property ($rose(sda_oe));
endmodule // lsrb_chk

// ==== verification/i2c_host_model.sv ====
// two-wire bus master; clock stands high between frames
`timescale 1ns/1ps
module i2c_host_model (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   initial begin
      scl = 1;
      sda_drv = 0;
   end
   // one bit: data moves mid-low, sampled at end of high
   task automatic bitx(input logic b, output logic r);
      #12 sda_drv = !b;
      #12 scl = 1;
      #24 r = sda;
      scl = 0;
   endtask
   // start or repeated start
   task automatic start();
      #12 sda_drv = 0;
      #12 scl = 1;
      #12 sda_drv = 1;
      #12 scl = 0;
   endtask
   task automatic stop();
      #12 sda_drv = 1;
      #12 scl = 1;
      #12 sda_drv = 0;
      #12;
   endtask
   // byte out msb first; rel high frees the ninth bit
   task automatic xfer(input logic [7:0] w, input logic rel,
      output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitx(w[i], b);
         r[i] = b;
      end
      bitx(rel, b);
      ack = !b;
   endtask
endmodule // i2c_host_model

// ==== verification/light_sensor_register_bank_tb.sv ====
// self-checking bench for the light sensor register bank
`timescale 1ns/1ps
module light_sensor_register_bank_tb;
   logic core_clk = 0;
   logic rst_b = 0;
   logic clk_en = 1;
   logic [1:0] addr_sel = 2'b00;
   logic [15:0] ch0_count, ch1_count, thr;
   wire scl_in;
   logic m_drv, sda_oe, sda_out, ack, rd_v = 0;
   wire sda_in = !(m_drv || sda_oe); // pull-up wire
   logic power_on, gain_high, integrating, result_ready, irq_clear;
   logic [15:0] low_threshold, high_threshold;
   logic [7:0] alert_config, rd, exp_q[$];
   int error_cnt = 0;
   int samples_checked = 0;
   int k, ready_cnt = 0, clr_cnt = 0; // pulse counters from the monitor
   int unsigned seed = 88122;
   always #2.5 core_clk = !core_clk;
   light_sensor_register_bank #(.FAST_CYCLES(20), .MEDIUM_CYCLES(40),
      .SLOW_CYCLES(80)) dut_u (.*);
   i2c_host_model h_u (.scl(scl_in), .sda_drv(m_drv), .sda(sda_in));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // write frame: command byte then n data bytes, low first
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d, int n);
      logic [7:0] r;
      h_u.start();
      h_u.xfer(8'h52, 1, r, ack);
      check(ack, 1);
      h_u.xfer(cmd, 1, r, ack);
      for (int i = 0; i < n; i++)
         h_u.xfer(d[8*i +: 8], 1, r, ack);
      h_u.stop();
   endtask
   // read frame of n bytes, nack on the last
   task automatic rdn(input int n);
      logic [7:0] r;
      h_u.start();
      h_u.xfer(8'h53, 1, r, ack);
      for (int i = 0; i < n; i++) begin
         h_u.xfer(8'hFF, i == n - 1, rd, ack);
         rd_v = !rd_v;
      end
      h_u.stop();
   endtask
   // scoreboard: oldest note against each byte read
   always @(rd_v) check(rd, exp_q.pop_front());
   // one-cycle pulses counted away from the launching edge
   always @(negedge core_clk) begin
      if (result_ready === 1) ready_cnt++;
      if (irq_clear === 1) clr_cnt++;
   end
   initial begin
      #100000 check(0, 1);
      conclude();
   end
   initial begin
      {ch1_count, ch0_count} = xs();
      thr = 16'(xs());
      repeat (6) @(posedge core_clk);
      #1 rst_b = 1;
      repeat (6) @(posedge core_clk);
      wr(8'h81, 0, 0);
      exp_q.push_back(8'h02);
      rdn(1);
      wr(8'h80, 16'h0003, 1);
      check(power_on, 1);
      exp_q.push_back(8'h03);
      rdn(1);
      wr(8'h81, 16'h0010, 1);
      check(gain_high, 1);
      wr(8'hA2, thr, 2);
      check(low_threshold, thr);
      wr(8'hA4, ~thr, 2);
      check(high_threshold, ~thr);
      wr(8'h86, 16'h00FF, 1);
      check(alert_config, 8'h3F);
      for (k = 0; k < 100 && result_ready !== 1; k++) @(negedge core_clk);
      check(result_ready, 1);
      // freeze right after a result: no new pulse may appear meanwhile
      @(posedge core_clk) #1 clk_en = 0;
      k = ready_cnt;
      repeat (30) @(posedge core_clk);
      #1 clk_en = 1;
      check(16'(ready_cnt - k), 0);
      wr(8'h9B, 0, 0);
      exp_q = {8'h04, ch0_count[7:0], ch0_count[15:8], ch1_count[7:0],
         ch1_count[15:8]};
      rdn(5);
      wr(8'h87, 0, 0);
      exp_q.push_back(8'h00);
      rdn(1);
      wr(8'hC0, 0, 0);
      check(16'(clr_cnt), 1);
      wr(8'h80, 16'h0000, 1);
      check(power_on, 0);
      @(negedge core_clk) check(integrating, 0);
      conclude();
   end
endmodule // light_sensor_register_bank_tb
bind light_sensor_register_bank lsrb_chk chk_u (.*);
